// ---- hw/link_shifter.sv ----
// host-side byte shifter running on the host serial clock
`timescale 1ns/1ns
module link_shifter (
	input  wire logic                            i_sclk,
	input  wire logic                            i_rstn,
	input  wire logic                            i_host_port_select_n,
	input  wire logic                            i_sdi,
	input  wire logic [spi_relay_pkg::BYTE_W-1:0] i_read_word,
	output logic                                 o_byte_toggle,
	output spi_relay_pkg::link_byte_t            o_byte,
	output logic                                 o_sdo,
	output logic                                 o_sdo_oe
);
	import spi_relay_pkg::*;

	// ----------------------------------------------------------------
	// framing state, cleared whenever the select is released
	// ----------------------------------------------------------------
	logic                link_rstn;
	logic [2:0]          bit_cnt, next_bit_cnt;
	logic [BYTE_W-1:0]   shreg, next_shreg;
	logic                phase, next_phase;
	logic                op_read, next_op_read;
	logic [BYTE_W-1:0]   rd_s1, rd_s2;
	logic [BYTE_W-1:0]   full_byte;
	link_byte_t          next_byte;
	logic                next_toggle;

	assign link_rstn = i_rstn & ~i_host_port_select_n;
	assign full_byte = {shreg[BYTE_W-2:0], i_sdi};

	always_comb begin
		next_bit_cnt  = bit_cnt + 3'h1;
		next_shreg    = full_byte;
		next_phase    = phase;
		next_op_read  = op_read;
		next_byte     = o_byte;
		next_toggle   = o_byte_toggle;
		if (bit_cnt == LAST_BIT) begin
			next_phase  = ~phase;
			next_byte   = '{second: phase, data: full_byte};
			next_toggle = ~o_byte_toggle;
			if (!phase) begin
				next_op_read = full_byte[OP_RW_BIT] & ~full_byte[OP_TARGET_BIT];
			end
		end
	end

	always_ff @(posedge i_sclk or negedge link_rstn) begin
		if (!link_rstn) begin
			bit_cnt <= 3'h0;
			shreg   <= 8'h00;
			phase   <= 1'b0;
			op_read <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			phase   <= next_phase;
			op_read <= next_op_read;
		end
	end

	// ----------------------------------------------------------------
	// handed-over byte and its toggle survive select release
	// ----------------------------------------------------------------
	always_ff @(posedge i_sclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_byte        <= '0;
			o_byte_toggle <= 1'b0;
		end else begin
			o_byte        <= next_byte;
			o_byte_toggle <= next_toggle;
		end
	end

	// ----------------------------------------------------------------
	// read data: quasi-static word, two flops before use
	// ----------------------------------------------------------------
	always_ff @(posedge i_sclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_s1 <= 8'h00;
			rd_s2 <= 8'h00;
		end else begin
			rd_s1 <= i_read_word;
			rd_s2 <= rd_s1;
		end
	end

	// bits change on the falling edge so the host samples on the rising one
	always_ff @(negedge i_sclk or negedge link_rstn) begin
		if (!link_rstn) begin
			o_sdo    <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else begin
			o_sdo    <= rd_s2[~bit_cnt];
			o_sdo_oe <= phase & op_read;
		end
	end

endmodule : link_shifter

// ---- hw/serial_register_port.sv ----
// serial register port with command registers and secondary-panel relay
// What this block does
// - the host port moves 8-bit units and each access is two consecutive bytes.
// - the first byte of a pair is loaded as the operation byte steering the next byte.
// - the second byte either selects a command register or carries its value.
// - with the timing generator, a command applies at once, at the next line or at the next frame.
// - without the timing generator, a command applies at the first dot clock fall after it arrives.
// - the target flag sends the second byte to own registers at 0 or to the secondary panel at 1.
// - a relayed byte asserts both secondary selects and shifts out with the secondary clock.
// - the read/write flag makes the second byte a write at 0 and a read at 1.
// - reads come only from own registers; reads aimed at the secondary panel are not honoured.
// - the command/value flag marks a register number at 0 and a register value at 1.
// - during a relay the command/value flag is copied onto the secondary data/command pin.
// - all secondary-panel select, clock, data and data/command pins are driven outputs.
// - each command register has a fixed application point of command, line or frame.
// - without the timing generator, registers invalid in that mode read back their defaults.
`timescale 1ns/1ns
module serial_register_port (
	input  wire logic                  i_mclk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_sclk,
	input  wire logic                  i_host_port_select_n,
	input  wire logic                  i_sdi,
	input  wire logic                  i_dot_clock,
	input  wire logic                  i_tg_enable,
	input  wire logic                  i_line_start,
	input  wire logic                  i_frame_start,
	output logic                       o_sdo,
	output logic                       o_sdo_oe,
	output logic                       o_sub_select_low_active_n,
	output logic                       o_sub_select_high_active,
	output logic                       o_sub_clk,
	output logic                       o_sub_data,
	output logic                       o_sub_cmd_or_value,
	output spi_relay_pkg::cmd_bank_t   o_cmd_regs
);
	import spi_relay_pkg::*;

	// ----------------------------------------------------------------
	// host link, on the host serial clock
	// ----------------------------------------------------------------
	logic              byte_toggle;
	link_byte_t        link_byte;
	logic [BYTE_W-1:0] read_word, next_read_word;

	link_shifter u_link (
		.i_sclk               (i_sclk),
		.i_rstn               (i_rstn),
		.i_host_port_select_n (i_host_port_select_n),
		.i_sdi                (i_sdi),
		.i_read_word          (read_word),
		.o_byte_toggle        (byte_toggle),
		.o_byte               (link_byte),
		.o_sdo                (o_sdo),
		.o_sdo_oe             (o_sdo_oe)
	);

	// ----------------------------------------------------------------
	// crossings into the main clock
	// ----------------------------------------------------------------
	logic tog_s1, tog_s2, tog_s3;
	logic dot_s1, dot_s2, dot_s3;
	logic tg_s1, tg_mode;
	logic byte_ev, dot_fall;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tog_s1  <= 1'b0;
			tog_s2  <= 1'b0;
			tog_s3  <= 1'b0;
			dot_s1  <= 1'b0;
			dot_s2  <= 1'b0;
			dot_s3  <= 1'b0;
			tg_s1   <= 1'b0;
			tg_mode <= 1'b0;
		end else begin
			tog_s1  <= byte_toggle;
			tog_s2  <= tog_s1;
			tog_s3  <= tog_s2;
			dot_s1  <= i_dot_clock;
			dot_s2  <= dot_s1;
			dot_s3  <= dot_s2;
			tg_s1   <= i_tg_enable;
			tg_mode <= tg_s1;
		end
	end

	// only the toggle crosses; the link clock stops between frames
	// the byte word is held for a whole byte time, so it is stable here
	assign byte_ev  = tog_s2 ^ tog_s3;
	assign dot_fall = dot_s3 & ~dot_s2;

	// ----------------------------------------------------------------
	// pair decode, selection and pending write
	// ----------------------------------------------------------------
	logic [BYTE_W-1:0] serial_operation_byte, next_op;
	logic [IDX_W-1:0]  sel, next_sel;
	pending_t          pend, next_pend;
	logic              relay_go, next_relay_go;
	logic [BYTE_W-1:0] relay_byte, next_relay_byte;
	logic              relay_dc, next_relay_dc;
	logic              relay_busy;
	logic              fire;
	logic              own_write;
	reg_info_t         sel_info;

	assign sel_info  = reg_info(sel);
	assign own_write = byte_ev & link_byte.second & ~serial_operation_byte[OP_TARGET_BIT]
		& ~serial_operation_byte[OP_RW_BIT] & serial_operation_byte[OP_CMD_BIT];

	always_comb begin
		if (tg_mode) begin
			fire = (pend.point == PT_CMD)
				| ((pend.point == PT_LINE) & i_line_start)
				| ((pend.point == PT_FRAME) & i_frame_start);
		end else begin
			fire = dot_fall;
		end
	end

	always_comb begin
		next_op         = serial_operation_byte;
		next_sel        = sel;
		next_pend       = pend;
		next_relay_go   = 1'b0;
		next_relay_byte = relay_byte;
		next_relay_dc   = relay_dc;
		if (pend.valid && fire) begin
			next_pend.valid = 1'b0;
		end
		if (byte_ev) begin
			if (!link_byte.second) begin
				next_op = link_byte.data;
			end else if (serial_operation_byte[OP_TARGET_BIT]) begin
				if (!serial_operation_byte[OP_RW_BIT]) begin
					next_relay_go   = 1'b1;
					next_relay_byte = link_byte.data;
					next_relay_dc   = serial_operation_byte[OP_CMD_BIT];
				end
			end else if (!serial_operation_byte[OP_RW_BIT]) begin
				if (!serial_operation_byte[OP_CMD_BIT]) begin
					next_sel = link_byte.data[IDX_W-1:0];
				end else begin
					// a new value wins over the slot being freed this cycle
					next_pend = '{valid: 1'b1, idx: sel, val: link_byte.data,
						point: sel_info.point};
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			serial_operation_byte <= 8'h00;
			sel                   <= 6'h00;
			pend                  <= '{valid: 1'b0, idx: 6'h00, val: 8'h00, point: PT_CMD};
			relay_go              <= 1'b0;
			relay_byte            <= 8'h00;
			relay_dc              <= 1'b0;
		end else begin
			serial_operation_byte <= next_op;
			sel                   <= next_sel;
			pend                  <= next_pend;
			relay_go              <= next_relay_go;
			relay_byte            <= next_relay_byte;
			relay_dc              <= next_relay_dc;
		end
	end

	// ----------------------------------------------------------------
	// command register bank
	// ----------------------------------------------------------------
	cmd_bank_t next_regs;

	for (genvar i = 0; i < NREG; i++) begin : g_reg
		localparam reg_info_t RST_INFO = reg_info(IDX_W'(i));
		assign next_regs[i] = (pend.valid && fire && pend.idx == IDX_W'(i)) ? pend.val : o_cmd_regs[i];
		always_ff @(posedge i_mclk or negedge i_rstn) begin
			if (!i_rstn) begin
				o_cmd_regs[i] <= RST_INFO.dflt;
			end else begin
				o_cmd_regs[i] <= next_regs[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// read-back word toward the host link
	// ----------------------------------------------------------------
	// quasi-static word: the selection pair before a read gives it time to settle
	always_comb begin
		if (tg_mode || sel_info.no_tg_ok) begin
			next_read_word = o_cmd_regs[sel];
		end else begin
			next_read_word = sel_info.dflt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			read_word <= 8'h00;
		end else begin
			read_word <= next_read_word;
		end
	end

	// ----------------------------------------------------------------
	// secondary-panel relay
	// ----------------------------------------------------------------
	sub_relay u_relay (
		.i_mclk                    (i_mclk),
		.i_rstn                    (i_rstn),
		.i_start                   (relay_go),
		.i_byte                    (relay_byte),
		.i_dc                      (relay_dc),
		.o_busy                    (relay_busy),
		.o_sub_select_low_active_n (o_sub_select_low_active_n),
		.o_sub_select_high_active  (o_sub_select_high_active),
		.o_sub_clk                 (o_sub_clk),
		.o_sub_data                (o_sub_data),
		.o_sub_cmd_or_value        (o_sub_cmd_or_value)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence s_first_byte;
		byte_ev && !link_byte.second;
	endsequence

	sequence s_sub_write;
		byte_ev && link_byte.second && serial_operation_byte[OP_TARGET_BIT]
			&& !serial_operation_byte[OP_RW_BIT] && !relay_busy;
	endsequence

	sequence s_sub_read;
		byte_ev && link_byte.second && serial_operation_byte[OP_TARGET_BIT]
			&& serial_operation_byte[OP_RW_BIT] && !relay_busy;
	endsequence

	sequence s_select_byte;
		byte_ev && link_byte.second && !serial_operation_byte[OP_TARGET_BIT]
			&& !serial_operation_byte[OP_RW_BIT] && !serial_operation_byte[OP_CMD_BIT];
	endsequence

	sequence s_read_byte;
		byte_ev && link_byte.second && !serial_operation_byte[OP_TARGET_BIT]
			&& serial_operation_byte[OP_RW_BIT];
	endsequence

	a_op_load: assert property (s_first_byte |=> serial_operation_byte == $past(link_byte.data))
		else $error("operation byte not loaded");

	a_sel_update: assert property (s_select_byte |=> sel == $past(link_byte.data[IDX_W-1:0]))
		else $error("register selection not taken");

	a_value_pend: assert property (own_write |=> pend.valid && pend.val == $past(link_byte.data)
		&& pend.idx == $past(sel))
		else $error("register value not queued");

	a_imm_apply: assert property (tg_mode && pend.valid && pend.point == PT_CMD
		|=> o_cmd_regs[$past(pend.idx)] == $past(pend.val))
		else $error("immediate command not applied");

	a_line_wait: assert property (tg_mode && pend.valid && pend.point == PT_LINE && !i_line_start
		|=> pend.valid && o_cmd_regs[$past(pend.idx)] == $past(o_cmd_regs[pend.idx]))
		else $error("line command applied early");

	a_frame_apply: assert property (tg_mode && pend.valid && pend.point == PT_FRAME && i_frame_start
		|=> o_cmd_regs[$past(pend.idx)] == $past(pend.val))
		else $error("frame command not applied");

	a_dot_apply: assert property (!tg_mode && pend.valid && dot_fall && !own_write
		|=> !pend.valid && o_cmd_regs[$past(pend.idx)] == $past(pend.val))
		else $error("command not applied at dot clock fall");

	a_relay_start: assert property (s_sub_write |-> ##2 !o_sub_select_low_active_n
		&& o_sub_select_high_active && o_sub_cmd_or_value == $past(serial_operation_byte[OP_CMD_BIT], 2))
		else $error("secondary selects not asserted");

	a_relay_msb: assert property (s_sub_write |-> ##2 o_sub_data == $past(link_byte.data[BYTE_W-1], 2))
		else $error("relay does not start with msb");

	a_no_sub_read: assert property (s_sub_read |-> ##2 !relay_busy)
		else $error("read aimed at secondary panel relayed");

	a_read_keep: assert property (s_read_byte |=> $stable(sel))
		else $error("read pair changed the selection");

	a_sub_idle: assert property (!relay_busy |-> o_sub_select_low_active_n && !o_sub_select_high_active)
		else $error("secondary selects active while idle");

	a_dc_steady: assert property (!o_sub_select_low_active_n && $past(!o_sub_select_low_active_n)
		|-> $stable(o_sub_cmd_or_value))
		else $error("data/command pin moved mid byte");

	a_default_read: assert property (!tg_mode && !sel_info.no_tg_ok
		|=> read_word == $past(sel_info.dflt))
		else $error("invalid register not read as default");

endmodule : serial_register_port

// ---- hw/sub_relay.sv ----
// relay of one byte to the secondary panel controller
`timescale 1ns/1ns
module sub_relay (
	input  wire logic                             i_mclk,
	input  wire logic                             i_rstn,
	input  wire logic                             i_start,
	input  wire logic [spi_relay_pkg::BYTE_W-1:0] i_byte,
	input  wire logic                             i_dc,
	output logic                                  o_busy,
	output logic                                  o_sub_select_low_active_n,
	output logic                                  o_sub_select_high_active,
	output logic                                  o_sub_clk,
	output logic                                  o_sub_data,
	output logic                                  o_sub_cmd_or_value
);
	import spi_relay_pkg::*;

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	relay_state_t      state, next_state;
	logic [DIV_W-1:0]  div, next_div;
	logic [2:0]        bit_cnt, next_bit_cnt;
	logic [BYTE_W-1:0] shreg, next_shreg;
	logic              next_sel_n, next_sel_h, next_clk, next_dc;

	assign o_busy     = (state != RL_IDLE);
	assign o_sub_data = shreg[BYTE_W-1];

	always_comb begin
		next_state   = state;
		next_div     = div + 4'h1;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_sel_n   = o_sub_select_low_active_n;
		next_sel_h   = o_sub_select_high_active;
		next_clk     = o_sub_clk;
		next_dc      = o_sub_cmd_or_value;
		case (state)
			RL_IDLE: begin
				next_div = 4'h0;
				// a start while busy is dropped; the host must pace pairs
				if (i_start) begin
					next_state   = RL_LOW;
					next_shreg   = i_byte;
					next_bit_cnt = 3'h0;
					next_sel_n   = 1'b0;
					next_sel_h   = 1'b1;
					next_clk     = 1'b0;
					next_dc      = i_dc;
				end
			end
			RL_LOW: begin
				if (div == DIV_LAST) begin
					next_state = RL_HIGH;
					next_div   = 4'h0;
					next_clk   = 1'b1;
				end
			end
			RL_HIGH: begin
				if (div == DIV_LAST) begin
					next_div = 4'h0;
					if (bit_cnt == LAST_BIT) begin
						next_state = RL_IDLE;
						next_sel_n = 1'b1;
						next_sel_h = 1'b0;
					end else begin
						next_state   = RL_LOW;
						next_bit_cnt = bit_cnt + 3'h1;
						next_shreg   = {shreg[BYTE_W-2:0], 1'b0};
						next_clk     = 1'b0;
					end
				end
			end
			default: begin
				next_state = RL_IDLE;
				next_sel_n = 1'b1;
				next_sel_h = 1'b0;
				next_clk   = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state                     <= RL_IDLE;
			div                       <= 4'h0;
			bit_cnt                   <= 3'h0;
			shreg                     <= 8'h00;
			o_sub_select_low_active_n <= 1'b1;
			o_sub_select_high_active  <= 1'b0;
			o_sub_clk                 <= 1'b1;
			o_sub_cmd_or_value        <= 1'b0;
		end else begin
			state                     <= next_state;
			div                       <= next_div;
			bit_cnt                   <= next_bit_cnt;
			shreg                     <= next_shreg;
			o_sub_select_low_active_n <= next_sel_n;
			o_sub_select_high_active  <= next_sel_h;
			o_sub_clk                 <= next_clk;
			o_sub_cmd_or_value        <= next_dc;
		end
	end

endmodule : sub_relay

// ---- pkg/spi_relay_pkg.sv ----
// constants, types and command register table for the serial register port
package spi_relay_pkg;

	// ----------------------------------------------------------------
	// widths and operation byte fields
	// ----------------------------------------------------------------
	localparam int BYTE_W        = 8;
	localparam int IDX_W         = 6;
	localparam int NREG          = 64;
	localparam int OP_TARGET_BIT = 6;
	localparam int OP_RW_BIT     = 5;
	localparam int OP_CMD_BIT    = 0;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ----------------------------------------------------------------
	// timing of the relayed secondary-panel clock
	// ----------------------------------------------------------------
	localparam int MCLK_MHZ     = 50;
	localparam int SUB_HALF_NS  = 40;
	localparam int SUB_HALF_CYC = (SUB_HALF_NS * MCLK_MHZ + 999) / 1000;
	localparam int DIV_W        = 4;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SUB_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PT_CMD   = 3'b001,
		PT_LINE  = 3'b010,
		PT_FRAME = 3'b100
	} apply_point_t;

	typedef enum logic [2:0] {
		RL_IDLE = 3'b001,
		RL_LOW  = 3'b010,
		RL_HIGH = 3'b100
	} relay_state_t;

	typedef struct packed {
		logic              second;
		logic [BYTE_W-1:0] data;
	} link_byte_t;

	typedef struct packed {
		logic              valid;
		logic [IDX_W-1:0]  idx;
		logic [BYTE_W-1:0] val;
		apply_point_t      point;
	} pending_t;

	typedef struct packed {
		logic [BYTE_W-1:0] dflt;
		apply_point_t      point;
		logic              no_tg_ok;
	} reg_info_t;

	typedef logic [NREG-1:0][BYTE_W-1:0] cmd_bank_t;

	// ----------------------------------------------------------------
	// per-register default, application point, valid without generator
	// ----------------------------------------------------------------
	function automatic reg_info_t reg_info(input logic [IDX_W-1:0] idx);
		case (idx)
			6'h00: reg_info = '{8'h00, PT_FRAME, 1'b0};
			6'h01: reg_info = '{8'h0a, PT_FRAME, 1'b0};
			6'h02: reg_info = '{8'h02, PT_FRAME, 1'b0};
			6'h03: reg_info = '{8'h00, PT_CMD,   1'b0};
			6'h04: reg_info = '{8'h00, PT_FRAME, 1'b1};
			6'h05: reg_info = '{8'h00, PT_LINE,  1'b1};
			6'h06: reg_info = '{8'h02, PT_CMD,   1'b1};
			6'h08: reg_info = '{8'h0e, PT_CMD,   1'b0};
			6'h09: reg_info = '{8'h00, PT_FRAME, 1'b1};
			6'h0b: reg_info = '{8'h00, PT_CMD,   1'b1};
			6'h0c: reg_info = '{8'h0f, PT_CMD,   1'b1};
			6'h0d: reg_info = '{8'h35, PT_CMD,   1'b1};
			6'h0f: reg_info = '{8'h00, PT_CMD,   1'b1};
			6'h18: reg_info = '{8'h00, PT_CMD,   1'b1};
			6'h19: reg_info = '{8'h16, PT_CMD,   1'b1};
			6'h1a: reg_info = '{8'h15, PT_CMD,   1'b1};
			6'h1b: reg_info = '{8'h2a, PT_CMD,   1'b1};
			6'h1c: reg_info = '{8'h00, PT_CMD,   1'b1};
			6'h21: reg_info = '{8'h00, PT_CMD,   1'b1};
			6'h24: reg_info = '{8'h0f, PT_CMD,   1'b0};
			6'h25: reg_info = '{8'h1d, PT_CMD,   1'b0};
			6'h26: reg_info = '{8'h1e, PT_CMD,   1'b0};
			6'h27: reg_info = '{8'h2c, PT_CMD,   1'b0};
			6'h28: reg_info = '{8'h2d, PT_CMD,   1'b0};
			6'h29: reg_info = '{8'h3b, PT_CMD,   1'b0};
			6'h2a: reg_info = '{8'h0a, PT_CMD,   1'b0};
			default: reg_info = '{8'h00, PT_CMD, 1'b0};
		endcase
	endfunction : reg_info

endpackage : spi_relay_pkg

// ---- tb/host_model.sv ----
// host processor model driving the serial register port
`timescale 1ns/1ns
module host_model (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_sdi,
	input  wire logic i_sdo
);
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_sdi  = 1'b0;
	end
	// one byte pair msb first; clock runs only inside the frame
	task automatic pair(input logic [15:0] w, input logic hold, output logic [7:0] rd);
		o_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			o_sclk = 1'b0;
			o_sdi  = w[i];
			#15 o_sclk = 1'b1;
			if (i < 8)
				rd[i] = i_sdo;
			#15;
		end
		// released line must not show the last bit; a held frame goes straight on
		if (!hold) begin
			o_cs_n = 1'b1;
			o_sdi  = ~o_sdi;
		end
	endtask : pair
endmodule : host_model

// ---- tb/tb.sv ----
// self-checking bench for the serial register port
`timescale 1ns/1ns
module tb;
	import spi_relay_pkg::*;
	typedef struct {logic [7:0] idx, op, val, dflt; int pt;} row_t;
	row_t rows[4] = '{'{8'h03, 8'h01, 8'ha5, 8'h00, 0}, '{8'h05, 8'h01, 8'h3c, 8'h00, 1},
		'{8'h00, 8'h01, 8'h81, 8'h00, 2}, '{8'h0c, 8'h9f, 8'h5a, 8'h0f, 0}};
	logic       i_mclk, i_rstn, sclk, cs_n, sdi, dot, tg, line, frame;
	logic       sdo, oe, s_n, s_h, s_clk, s_dat, s_dc, p;
	logic [7:0] rd, sub;
	cmd_bank_t  regs;
	int         n_mismatch, cmp_count, w, nb, oe_cnt, n0;
	logic [15:0] rl[2] = '{16'h41c6, 16'h403a};
	serial_register_port u_serial_register_port (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_sclk(sclk),
		.i_host_port_select_n(cs_n), .i_sdi(sdi), .i_dot_clock(dot), .i_tg_enable(tg),
		.i_line_start(line), .i_frame_start(frame), .o_sdo(sdo), .o_sdo_oe(oe),
		.o_sub_select_low_active_n(s_n), .o_sub_select_high_active(s_h), .o_sub_clk(s_clk),
		.o_sub_data(s_dat), .o_sub_cmd_or_value(s_dc), .o_cmd_regs(regs));
	host_model u_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));
	// counts the rising edges at which the port drives read data
	always @(posedge sclk) begin
		if (oe)
			oe_cnt++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#2;
	endtask : tick
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk8
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// select pair then access pair, select held across all 32 bits
	task automatic acc(input logic [7:0] idx, input logic [15:0] w);
		u_host_model.pair({8'h00, idx}, 1'b1, rd);
		u_host_model.pair(w, 1'b0, rd);
		tick(8);
	endtask : acc
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	initial begin
		{i_rstn, line, frame} = 3'b000;
		{dot, tg} = 2'b11;
		tick(2);
		i_rstn = 1'b1;
		chk8(regs[13], 8'h35, "reset value");
		chk8({s_n, s_h, s_clk}, 8'h05, "sub idle");
		$display("reset done");
		tick(4);
		foreach (rows[k]) begin
			n0 = oe_cnt;
			acc(rows[k].idx, {rows[k].op, rows[k].val});
			chk8(8'(oe_cnt - n0), 8'h00, "drive on write");
			if (rows[k].pt != 0) begin
				chk8(regs[rows[k].idx], rows[k].dflt, "early");
				line  = (rows[k].pt == 1);
				frame = (rows[k].pt == 2);
				tick(1);
				{line, frame} = 2'b00;
				tick(2);
			end
			chk8(regs[rows[k].idx], rows[k].val, "apply");
			n0 = oe_cnt;
			acc(rows[k].idx, 16'h2000);
			chk8(rd, rows[k].val, "read");
			chk8(8'(oe_cnt - n0), 8'h08, "read drive");
			$display("row %0d done", k);
		end
		foreach (rl[r]) begin
			u_host_model.pair(rl[r], 1'b0, rd);
			w = 0;
			while (s_n !== 1'b0 && w < 50) begin
				tick(1);
				w++;
			end
			if (w >= 50) begin
				n_mismatch++;
				$display("[ERR] %0t relay never started", $time);
				end_of_test();
			end
			chk8({s_h, s_dc}, {7'h01, rl[r][8]}, "sub select");
			nb = 0;
			repeat (40) begin
				p = s_clk;
				tick(1);
				if (!p && s_clk) begin
					sub = {sub[6:0], s_dat};
					nb++;
				end
			end
			chk8(sub, rl[r][7:0], "relay");
			chk8(8'(nb), 8'h08, "bits");
			chk8({s_n, s_h, s_clk}, 8'h05, "sub end");
		end
		// a read aimed at the secondary panel must leave its pins alone
		u_host_model.pair(16'h60a5, 1'b0, rd);
		tick(8);
		chk8({s_n, s_h, s_clk}, 8'h05, "no sub read");
		$display("relay done");
		tg = 1'b0;
		tick(4);
		acc(8'h04, 16'h0177);
		chk8(regs[4], 8'h00, "before dot");
		dot = 1'b0;
		tick(5);
		chk8(regs[4], 8'h77, "dot fall");
		acc(8'h00, 16'h2000);
		chk8(rd, 8'h00, "default read");
		$display("no generator done");
		i_rstn = 1'b0;
		tick(2);
		i_rstn = 1'b1;
		chk8(regs[0], 8'h00, "mid reset");
		chk8({s_n, s_h, s_clk}, 8'h05, "mid reset sub");
		tick(4);
		acc(8'h04, 16'h2000);
		chk8(rd, 8'h00, "read after reset");
		$display("mid reset done");
		end_of_test();
	end
endmodule : tb
